// ### src/iodp_input_port.sv
// Input data port: format registers, link-side word assembly, parity check and slot steering.
// Assumes the sample source is timed to link_clk and the register port runs on clk.
`timescale 1ns/1ns
module iodp_input_port
  import iodp_pkg::*;
(
  input  wire logic        clk,               // Register side clock.
  input  wire logic        resetn,            // Asynchronous reset, active low.
  input  wire logic        link_clk,          // Sampling clock of the link.
  input  wire logic        reg_wr_en,         // Register write strobe.
  input  wire logic [7:0]  reg_addr,          // Register address.
  input  wire logic [7:0]  reg_wdata,         // Register write data.
  output logic [7:0]       reg_rdata,         // Registered read data.
  input  wire logic        bus_mode_pin,      // Bus mode strap pin.
  input  wire logic        ctrl_mode_pin,     // Control mode strap pin.
  input  wire logic [3:0]  channel_enable,    // Enabled datapath channels.
  input  wire logic [31:0] data_in,           // Sample bus from the source.
  input  wire logic        frame_sync,        // Frame sync from the source.
  input  wire logic        parity_in,         // Parity line from the source.
  output logic             data_clock_output, // Data clock returned to the source.
  output iodp_smp_type     sample,            // Assembled sample.
  output logic             sample_valid,      // Sample is present.
  input  wire logic        sample_ready,      // Datapath takes the sample.
  output logic             parity_error,      // Sticky parity mismatch.
  output logic             overrun_error,     // Sticky word loss on a full buffer.
  input  wire logic        error_clear        // Clears both sticky flags.
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} iodp_st_type;

  // Register side state.
  logic [7:0]   if_cfg_ff, fmt_cfg_ff, rdata_ff;
  logic [1:0]   bus_pin_ff, ctrl_pin_ff;
  logic [2:0]   perr_sync_ff, ovr_sync_ff;
  logic         perr_ff, ovr_ff;
  iodp_cfg_type cfg_c;

  // Link side state.
  logic [1:0]   lrst_ff;
  iodp_cfg_type cfg_s1_ff, cfg_l;
  logic [31:0]  din_ff;
  logic         fs_ff, fs_d_ff, par_ff;
  iodp_st_type  st_ff;
  logic [2:0]   cnt_ff;
  logic [1:0]   beat_ff, chan_ff;
  logic         quad_ff;
  logic [15:0]  asm_ff, nxt_asm;
  logic         perr_tgl_ff, ovr_tgl_ff;

  // Register write decode and read selection.
  wire wr_if   = reg_wr_en & (reg_addr == IODP_ADDR_IF_CFG);
  wire wr_fmt  = reg_wr_en & (reg_addr == IODP_ADDR_FMT_CFG);
  wire [7:0] if_rd = {bus_pin_ff[1], ctrl_pin_ff[1], 1'b0, if_cfg_ff[4:0]};
  wire [7:0] rd_sel = (reg_addr == IODP_ADDR_IF_CFG)  ? if_rd :
                      (reg_addr == IODP_ADDR_FMT_CFG) ? fmt_cfg_ff : 8'h00;
  wire perr_evt_c = perr_sync_ff[2] ^ perr_sync_ff[1];
  wire ovr_evt_c  = ovr_sync_ff[2] ^ ovr_sync_ff[1];

  // Settings gathered for the link side.
  assign cfg_c.dco_inv    = if_cfg_ff[IF_DCO_INV_BIT];
  assign cfg_c.qduc       = if_cfg_ff[IF_MODE_BIT];
  assign cfg_c.chan_pri   = if_cfg_ff[IF_PRI_BIT];
  assign cfg_c.par        = iodp_par_type'(if_cfg_ff[IF_PAR_LO +: 2]);
  assign cfg_c.offset_bin = fmt_cfg_ff[FMT_CODING_BIT];
  assign cfg_c.bus        = iodp_bus_type'(fmt_cfg_ff[FMT_BUS_LO +: 2]);
  assign cfg_c.word16     = fmt_cfg_ff[FMT_WORD_BIT];
  assign cfg_c.sample_type_select      = fmt_cfg_ff[FMT_SAMPLE_TYPE_SELECT_BIT];
  assign cfg_c.lat        = fmt_cfg_ff[FMT_LAT_LO +: 3];
  assign cfg_c.ch_en      = channel_enable;
  assign reg_rdata     = rdata_ff;
  assign parity_error  = perr_ff;
  assign overrun_error = ovr_ff;

  // Registers, strap synchronisers and event receivers on clk.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      if_cfg_ff    <= IODP_IF_CFG_RST;
      fmt_cfg_ff   <= IODP_FMT_CFG_RST;
      rdata_ff     <= 8'h00;
      bus_pin_ff   <= 2'h0;
      ctrl_pin_ff  <= 2'h0;
      perr_sync_ff <= 3'h0;
      ovr_sync_ff  <= 3'h0;
      perr_ff      <= 1'b0;
      ovr_ff       <= 1'b0;
    end else begin
      if (wr_if) begin
        if_cfg_ff <= reg_wdata;
      end
      if (wr_fmt) begin
        fmt_cfg_ff <= reg_wdata;
      end
      rdata_ff     <= rd_sel;
      bus_pin_ff   <= {bus_pin_ff[0], bus_mode_pin};
      ctrl_pin_ff  <= {ctrl_pin_ff[0], ctrl_mode_pin};
      perr_sync_ff <= {perr_sync_ff[1:0], perr_tgl_ff};
      ovr_sync_ff  <= {ovr_sync_ff[1:0], ovr_tgl_ff};
      // A new event wins over a clear in the same cycle.
      perr_ff <= perr_evt_c | (perr_ff & ~error_clear);
      ovr_ff  <= ovr_evt_c | (ovr_ff & ~error_clear);
    end
  end

  // Link reset: asserted at once, released after two link edges.
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      lrst_ff <= 2'h0;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'b1};
    end
  end
  wire lrstn = lrst_ff[1];

  // Settings are quasi-static; change them only while frames are stopped.
  always_ff @(posedge link_clk or negedge lrstn) begin
    if (!lrstn) begin
      cfg_s1_ff <= '0;
      cfg_l     <= '0;
    end else begin
      cfg_s1_ff <= cfg_c;
      cfg_l     <= cfg_s1_ff;
    end
  end

  // The returned clock follows the link clock, optionally inverted.
  assign data_clock_output = link_clk ^ cfg_l.dco_inv;

  // Upconverter mode overrides priority, bus and word width.
  wire          qduc      = cfg_l.qduc;
  wire          pri_eff   = cfg_l.chan_pri & ~qduc;
  iodp_bus_type bus_eff;
  assign bus_eff = qduc ? BUS_32 : cfg_l.bus;
  wire          word16    = qduc | cfg_l.word16;
  wire [1:0]    beats_m1  = (bus_eff == BUS_4) ? (word16 ? 2'h3 : 2'h1) :
                            (bus_eff == BUS_8 && word16) ? 2'h1 : 2'h0;

  // Frame start and sampling window.
  wire fs_fall = fs_d_ff & ~fs_ff;
  wire take    = ~fs_ff & ((st_ff == ST_RUN) | (fs_fall & (cfg_l.lat == 3'h0)) |
                           ((st_ff == ST_WAIT) & (cnt_ff == cfg_l.lat)));
  wire word_done = take & (beat_ff == beats_m1);

  // Each beat shifts in at the top; wide buses deliver the word in one beat.
  always_comb begin
    case (bus_eff)
      BUS_4:   nxt_asm = {din_ff[3:0], asm_ff[15:4]};
      BUS_8:   nxt_asm = {din_ff[7:0], asm_ff[15:8]};
      default: nxt_asm = din_ff[15:0];
    endcase
  end

  // Word extraction, coding conversion and sign extension.
  wire [7:0]  w8     = (bus_eff == BUS_4 || bus_eff == BUS_8) ? nxt_asm[15:8] : nxt_asm[7:0];
  wire [15:0] w_raw  = word16 ? nxt_asm : {8'h00, w8};
  wire [7:0]  w8_tc  = w8 ^ {cfg_l.offset_bin, 7'h00};
  wire [15:0] w16_tc = nxt_asm ^ {cfg_l.offset_bin, 15'h0000};
  wire [15:0] w_tc   = word16 ? w16_tc : {{8{w8_tc[7]}}, w8_tc};

  // Parity check of the completed word.
  wire par_bad = (cfg_l.par == PAR_EVEN) ? (^w_raw ^ par_ff) :
                 (cfg_l.par == PAR_ODD)  ? ~(^w_raw ^ par_ff) :
                 (cfg_l.par == PAR_IQ)   ? (par_ff != quad_ff) : 1'b0;
  wire perr = word_done & par_bad;

  // Next slot: all four in priority mode, else the next enabled channel.
  function automatic logic [1:0] next_en(input logic [1:0] cur, input logic [3:0] en);
    logic [1:0] res;
    logic [1:0] idx;
    res = cur;
    for (int i = 3; i >= 1; i--) begin
      idx = cur + 2'(i);
      if (en[idx]) begin
        res = idx;
      end
    end
    return res;
  endfunction : next_en

  wire [1:0] chan_nxt = pri_eff ? (chan_ff + 2'h1) : next_en(chan_ff, cfg_l.ch_en);
  wire [1:0] chan_1st = pri_eff ? 2'h0 : next_en(2'h3, cfg_l.ch_en);
  wire       slot_end = ~cfg_l.sample_type_select | quad_ff;
  wire       keep     = word_done & cfg_l.ch_en[chan_ff];
  logic      fifo_w_ready;
  wire       push     = keep & fifo_w_ready;
  wire       overrun  = keep & ~fifo_w_ready;
  iodp_smp_type w_smp;
  assign w_smp.data = w_tc;
  assign w_smp.chan = chan_ff;
  assign w_smp.quad = quad_ff;

  // Link-side pin capture and sampling window.
  always_ff @(posedge link_clk or negedge lrstn) begin
    if (!lrstn) begin
      din_ff  <= 32'h0000_0000;
      fs_ff   <= 1'b0;
      fs_d_ff <= 1'b0;
      par_ff  <= 1'b0;
      st_ff   <= ST_IDLE;
      cnt_ff  <= 3'h0;
    end else begin
      din_ff  <= data_in;
      fs_ff   <= frame_sync;
      fs_d_ff <= fs_ff;
      par_ff  <= parity_in;
      if (fs_ff) begin
        st_ff <= ST_IDLE;
      end else if (fs_fall) begin
        st_ff  <= (cfg_l.lat == 3'h0) ? ST_RUN : ST_WAIT;
        cnt_ff <= 3'h1;
      end else if (st_ff == ST_WAIT) begin
        if (cnt_ff == cfg_l.lat) begin
          st_ff <= ST_RUN;
        end
        cnt_ff <= cnt_ff + 3'h1;
      end
    end
  end

  // Beat, slot and event toggles.
  always_ff @(posedge link_clk or negedge lrstn) begin
    if (!lrstn) begin
      asm_ff      <= 16'h0000;
      beat_ff     <= 2'h0;
      chan_ff     <= 2'h0;
      quad_ff     <= 1'b0;
      perr_tgl_ff <= 1'b0;
      ovr_tgl_ff  <= 1'b0;
    end else begin
      if (fs_fall) begin
        beat_ff <= 2'h0;
        chan_ff <= chan_1st;
        quad_ff <= 1'b0;
      end
      if (take) begin
        asm_ff  <= nxt_asm;
        beat_ff <= word_done ? 2'h0 : beat_ff + 2'h1;
      end
      if (word_done) begin
        quad_ff <= cfg_l.sample_type_select & ~quad_ff;
        if (slot_end) begin
          chan_ff <= chan_nxt;
        end
      end
      perr_tgl_ff <= perr_tgl_ff ^ perr;
      ovr_tgl_ff  <= ovr_tgl_ff ^ overrun;
    end
  end

  // Four-word buffer; a full buffer drops the word and raises the overrun flag.
  iodp_fifo #(.W($bits(iodp_smp_type)), .DEPTH(IODP_FIFO_DEPTH)) u_fifo (
    .wclk    (link_clk),
    .wrst_n  (lrstn),
    .w_valid (keep),
    .w_ready (fifo_w_ready),
    .w_data  (w_smp),
    .rclk    (clk),
    .rrst_n  (resetn),
    .r_valid (sample_valid),
    .r_ready (sample_ready),
    .r_data  (sample)
  );

  // Checks on the link side; the sticky flag check runs on clk.
  sequence s_fs_fall;
    fs_fall;
  endsequence
  sequence s_nib_start;
    take && beat_ff == 2'h0 && bus_eff == BUS_4 && word16;
  endsequence

  AST_SLOT_EN: assert property (@(posedge link_clk) disable iff (!lrstn)
    push && !pri_eff |-> cfg_l.ch_en[chan_ff]) else $error("word stored for a disabled channel");
  AST_ALL_SLOTS: assert property (@(posedge link_clk) disable iff (!lrstn)
    word_done && pri_eff && !cfg_l.sample_type_select && !fs_fall |=> chan_ff == $past(chan_ff) + 2'h1)
    else $error("priority mode skipped a slot");
  AST_DROP: assert property (@(posedge link_clk) disable iff (!lrstn)
    word_done && !cfg_l.ch_en[chan_ff] |-> !push) else $error("disabled channel word kept");
  AST_PAR_OFF: assert property (@(posedge link_clk) disable iff (!lrstn)
    cfg_l.par == PAR_OFF |-> !perr) else $error("parity error with checking off");
  AST_PAR_EVEN: assert property (@(posedge link_clk) disable iff (!lrstn)
    word_done && cfg_l.par == PAR_EVEN |-> perr == (^w_raw ^ par_ff)) else $error("even parity wrong");
  AST_PAR_IQ: assert property (@(posedge link_clk) disable iff (!lrstn)
    word_done && cfg_l.par == PAR_IQ |-> perr == (par_ff != quad_ff)) else $error("IQ parity wrong");
  AST_CODING: assert property (@(posedge link_clk) disable iff (!lrstn)
    push && word16 |-> w_smp.data[15] == (nxt_asm[15] ^ cfg_l.offset_bin)) else $error("coding wrong");
  AST_NIBBLES: assert property (@(posedge link_clk) disable iff (!lrstn)
    s_nib_start ##1 (take && !fs_fall)[*3] |-> word_done) else $error("four nibbles did not make a word");
  AST_WORD8: assert property (@(posedge link_clk) disable iff (!lrstn)
    push && !word16 |-> w_smp.data[15:8] == {8{w_smp.data[7]}}) else $error("8-bit word not extended");
  AST_REAL: assert property (@(posedge link_clk) disable iff (!lrstn)
    word_done && !cfg_l.sample_type_select |-> !quad_ff) else $error("real data marked quadrature");
  AST_LAT0: assert property (@(posedge link_clk) disable iff (!lrstn)
    s_fs_fall ##0 cfg_l.lat == 3'h0 |-> take) else $error("latency 0 missed first edge");
  AST_LAT2: assert property (@(posedge link_clk) disable iff (!lrstn)
    s_fs_fall ##0 (cfg_l.lat == 3'h2 && !take) ##1 (!fs_ff && !take) ##1 !fs_ff |-> take)
    else $error("latency 2 did not start at third edge");
  AST_QDUC: assert property (@(posedge link_clk) disable iff (!lrstn)
    qduc |-> !pri_eff && bus_eff == BUS_32 && word16) else $error("upconverter mode not forced");
  AST_STICKY: assert property (@(posedge clk) disable iff (!resetn)
    perr_evt_c |=> parity_error [*2]) else $error("parity flag lost");
endmodule : iodp_input_port

// ### src/iodp_pkg.sv
// Package for the input data port format block: register map, field layout, encodings and carriers.
// Assumes a byte-wide register write port and a sample source clocked by the link clock.
// Notes on behaviour
// - Priority bit 0: samples taken only for enabled channels, no slots for others.
// - Priority bit 1: all four slots consumed, disabled channel samples discarded.
// - Parity field 00 off, 10 even, 11 odd parity over each word.
// - Parity field 01: parity input 0 on in-phase words, 1 on quadrature words.
// - Coding bit 0 means twos complement input, 1 means offset binary input.
// - Bus width field 00, 01, 10, 11 selects 4, 8, 16, 32 bit bus.
// - Word width bit 0 builds 8-bit words, 1 builds 16-bit words.
// - Sample type bit 0 means real words, 1 means in-phase/quadrature pairs.
// - Latency n starts sampling at link edge n+1 after frame sync falls.
// - Priority bit acts in channelizer mode only, ignored in upconverter mode.
// - Upconverter mode forces a 32-bit bus with 16-bit words.
package iodp_pkg;

  // Register addresses and reset values.
  localparam logic [7:0] IODP_ADDR_IF_CFG  = 8'h20;
  localparam logic [7:0] IODP_ADDR_FMT_CFG = 8'h21;
  localparam logic [7:0] IODP_IF_CFG_RST   = 8'h00;
  localparam logic [7:0] IODP_FMT_CFG_RST  = 8'h00;

  // Field positions of the interface configuration register.
  localparam int IF_BUS_PIN_BIT  = 7;
  localparam int IF_CTRL_PIN_BIT = 6;
  localparam int IF_DCO_INV_BIT  = 4;
  localparam int IF_MODE_BIT     = 3;
  localparam int IF_PRI_BIT      = 2;
  localparam int IF_PAR_LO       = 0;

  // Field positions of the data format register.
  localparam int FMT_CODING_BIT  = 7;
  localparam int FMT_BUS_LO      = 5;
  localparam int FMT_WORD_BIT    = 4;
  localparam int FMT_SAMPLE_TYPE_SELECT_BIT   = 3;
  localparam int FMT_LAT_LO      = 0;

  localparam int IODP_FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    PAR_OFF  = 2'h0,
    PAR_IQ   = 2'h1,
    PAR_EVEN = 2'h2,
    PAR_ODD  = 2'h3
  } iodp_par_type;

  typedef enum logic [1:0] {
    BUS_4  = 2'h0,
    BUS_8  = 2'h1,
    BUS_16 = 2'h2,
    BUS_32 = 2'h3
  } iodp_bus_type;

  // Settings carried from the register domain into the link domain.
  typedef struct packed {
    logic         dco_inv;
    logic         qduc;
    logic         chan_pri;
    iodp_par_type par;
    logic         offset_bin;
    iodp_bus_type bus;
    logic         word16;
    logic         sample_type_select;
    logic [2:0]   lat;
    logic [3:0]   ch_en;
  } iodp_cfg_type;

  // One assembled sample word with its slot.
  typedef struct packed {
    logic [15:0] data;
    logic [1:0]  chan;
    logic        quad;
  } iodp_smp_type;

endpackage : iodp_pkg

// ### src/iodp_fifo.sv
// Dual-clock sample FIFO with gray-coded pointers and a registered read port.
// Assumes DEPTH is a power of two, at least 4, and both resets are released cleanly per domain.
`timescale 1ns/1ns
module iodp_fifo #(
  parameter int W     = 19,
  parameter int DEPTH = 4
) (
  input  wire logic         wclk,     // Write side clock.
  input  wire logic         wrst_n,   // Write side reset, active low.
  input  wire logic         w_valid,  // Word offered.
  output logic              w_ready,  // Room for a word.
  input  wire logic [W-1:0] w_data,   // Word written.
  input  wire logic         rclk,     // Read side clock.
  input  wire logic         rrst_n,   // Read side reset, active low.
  output logic              r_valid,  // Output register holds a word.
  input  wire logic         r_ready,  // Reader takes the word.
  output logic [W-1:0]      r_data    // Registered output word.
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_ff, wgray_ff, rbin_ff, rgray_ff;
  logic [AW:0]  rq1_ff, rq2_ff, wq1_ff, wq2_ff;
  logic [AW:0]  nxt_wbin, nxt_rbin;
  logic [W-1:0] r_data_ff;
  logic         r_valid_ff;
  wire          push = w_valid & w_ready;
  wire          empty = (rgray_ff == wq2_ff);
  wire          pop = ~empty & (~r_valid_ff | r_ready);

  // Full when the write pointer is one lap ahead of the synchronised read pointer.
  assign w_ready  = (wgray_ff != {~rq2_ff[AW:AW-1], rq2_ff[AW-2:0]});
  assign nxt_wbin = wbin_ff + 1'b1;
  assign nxt_rbin = rbin_ff + 1'b1;
  assign r_valid  = r_valid_ff;
  assign r_data   = r_data_ff;

  // Storage has no reset; only words behind a valid pointer are ever read.
  always_ff @(posedge wclk) begin
    if (push) begin
      mem[wbin_ff[AW-1:0]] <= w_data;
    end
  end

  // Write pointer and read pointer synchroniser.
  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      wbin_ff  <= '0;
      wgray_ff <= '0;
      rq1_ff   <= '0;
      rq2_ff   <= '0;
    end else begin
      rq1_ff <= rgray_ff;
      rq2_ff <= rq1_ff;
      if (push) begin
        wbin_ff  <= nxt_wbin;
        wgray_ff <= nxt_wbin ^ (nxt_wbin >> 1);
      end
    end
  end

  // Read pointer, write pointer synchroniser and the output register.
  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rbin_ff    <= '0;
      rgray_ff   <= '0;
      wq1_ff     <= '0;
      wq2_ff     <= '0;
      r_valid_ff <= 1'b0;
      r_data_ff  <= '0;
    end else begin
      wq1_ff     <= wgray_ff;
      wq2_ff     <= wq1_ff;
      r_valid_ff <= pop | (r_valid_ff & ~r_ready);
      if (pop) begin
        r_data_ff <= mem[rbin_ff[AW-1:0]];
        rbin_ff   <= nxt_rbin;
        rgray_ff  <= nxt_rbin ^ (nxt_rbin >> 1);
      end
    end
  end
endmodule : iodp_fifo

// ### verif/iodp_src.sv
// Sample source model: drives words, frame sync and parity on the link clock.
// Assumes the bench calls send between frames and the port captures on rising link edges.
`timescale 1ns/1ns
module iodp_src (
  input  wire logic   link_clk,   // Link clock.
  output logic [31:0] data_in,    // Sample bus.
  output logic        frame_sync, // Frame sync, high when idle.
  output logic        parity_in   // Parity line.
);
  logic busy;
  // Start idle with sync high.
  initial begin
    busy = 1'b0;
    data_in = 32'h5a5a5a5a;
    frame_sync = 1'b1;
    parity_in = 1'b0;
  end
  // Outside frames the lines toggle so that a stale word cannot pass for a fresh one.
  always @(posedge link_clk) begin
    if (!busy) begin
      data_in <= ~data_in;
      parity_in <= ~parity_in;
    end
  end
  // One frame: sync low, filler for the latency, then the beats of each word, low part first.
  task automatic send(input logic [15:0] w [16], input int n, input logic [15:0] q, input int lat,
                      input int bw, input int wb, input logic [1:0] par, input int bad);
    logic [15:0] m;
    logic [15:0] wm;
    logic        p;
    busy = 1'b1;
    m = 16'((32'h1 << bw) - 1);
    wm = (wb == 16) ? 16'hffff : 16'h00ff;
    @(posedge link_clk);
    frame_sync <= 1'b0;
    repeat (lat) begin
      data_in <= ~data_in;
      @(posedge link_clk);
    end
    for (int i = 0; i < n; i++) begin
      p = ((par == 2'h1) ? q[i] : (^(w[i] & wm)) ^ (par == 2'h3)) ^ (i == bad);
      for (int b = 0; b < wb / bw; b++) begin
        data_in <= (~data_in & ~{16'h0, m}) | {16'h0, (w[i] >> (b * bw)) & m};
        parity_in <= p;
        @(posedge link_clk);
      end
    end
    frame_sync <= 1'b1;
    busy = 1'b0;
  endtask : send
endmodule : iodp_src

// ### verif/tb_input_data_port_format_config.sv
// Self-checking bench for the input port: registers, framing, slots, coding, parity and overrun.
// Assumes iodp_src stands at the link and the design carries its own assertions.
`timescale 1ns/1ns
module tb_input_data_port_format_config
  import iodp_pkg::*;
();
  logic         clk, resetn, link_clk, reg_wr_en, bus_mode_pin, ctrl_mode_pin;
  logic         sample_valid, sample_ready, parity_error, overrun_error, error_clear, stall;
  logic         data_clock_output;
  wire logic    frame_sync, parity_in;
  wire logic [31:0] data_in;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata;
  logic [3:0]   channel_enable;
  logic [31:0]  rnd;
  iodp_smp_type sample;
  logic [18:0]  expq [$];
  int           n_errors, checked;
  bit           timed_out;
  // Table: [23:16] interface byte, [15:8] format byte, [7:4] enables, [1] stall, [0] bad parity.
  logic [23:0]  tbl [9] = '{24'h025030, 24'h0363a1, 24'h05df60, 24'h013a91, 24'h0081f1,
                            24'h021540, 24'h0e8150, 24'h125000, 24'h0610f2};

  iodp_input_port u_dut (.clk(clk), .resetn(resetn), .link_clk(link_clk), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_mode_pin(bus_mode_pin),
    .ctrl_mode_pin(ctrl_mode_pin), .channel_enable(channel_enable), .data_in(data_in),
    .frame_sync(frame_sync), .parity_in(parity_in), .data_clock_output(data_clock_output),
    .sample(sample), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .parity_error(parity_error), .overrun_error(overrun_error), .error_clear(error_clear));
  iodp_src u_src (.link_clk(link_clk), .data_in(data_in), .frame_sync(frame_sync), .parity_in(parity_in));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("mismatches=%0d comparisons=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1;
    check(32'(reg_rdata), 32'(exp));
  endtask : rd
  // One frame: program, work out the kept words from the slot walk, send, drain, check flags.
  task automatic frame(input logic [23:0] e);
    logic [15:0] w [16];
    logic [15:0] q, v;
    logic [7:0]  ifb, fmt;
    logic [31:0] s;
    logic        qd, pri, ob;
    int          c, n, bw, wb, kept, to;
    ifb = e[23:16];
    fmt = e[15:8];
    wr(IODP_ADDR_IF_CFG, ifb);
    wr(IODP_ADDR_FMT_CFG, fmt);
    // Both change right at the clock edge that ends the write.
    channel_enable <= e[7:4];
    stall <= e[1];
    rd(IODP_ADDR_FMT_CFG, fmt);
    repeat (12) @(posedge clk);
    wb = (fmt[FMT_WORD_BIT] || ifb[IF_MODE_BIT]) ? 16 : 8;
    bw = ifb[IF_MODE_BIT] ? 16 : (fmt[FMT_BUS_LO+:2] == BUS_4) ? 4 : (fmt[FMT_BUS_LO+:2] == BUS_8) ? 8 : wb;
    pri = ifb[IF_PRI_BIT] && !ifb[IF_MODE_BIT];
    ob = fmt[FMT_CODING_BIT];
    // Full-rate frames stay within the buffer so that random stalls cannot drop words.
    n = (e[1] || wb > bw) ? 8 : 4;
    c = 0;
    while (!pri && c < 4 && !e[4 + c]) c++;
    qd = 1'b0;
    q = 16'h0;
    kept = 0;
    s = rnd;
    for (int i = 0; i < n; i++) begin
      s = lfsr(s);
      w[i] = s[15:0];
      q[i] = qd;
      v = (wb == 16) ? w[i] ^ {ob, 15'h0} : {{9{w[i][7] ^ ob}}, w[i][6:0]};
      if (c < 4 && e[4 + c] && (!e[1] || kept < 5)) begin
        expq.push_back({v, c[1:0], qd});
        kept++;
      end
      if (fmt[FMT_SAMPLE_TYPE_SELECT_BIT] && !qd) qd = 1'b1;
      else begin
        qd = 1'b0;
        c = (c + 1) % 4;
        while (!pri && e[7:4] != 4'h0 && !e[4 + c]) c = (c + 1) % 4;
      end
    end
    u_src.send(w, n, q, int'(fmt[FMT_LAT_LO+:3]), bw, wb, ifb[IF_PAR_LO+:2], e[0] ? 1 : -1);
    if (e[1]) begin
      repeat (10) @(posedge clk);
      check(32'(overrun_error), 32'h1);
      stall <= 1'b0;
    end
    to = 0;
    while (expq.size() != 0 && to < 400) begin
      @(posedge clk);
      to++;
    end
    if (to >= 400) begin
      n_errors++;
      timed_out = 1'b1;
      return;
    end
    repeat (10) @(posedge clk);
    #1;
    check(32'(parity_error), 32'(e[0] && ifb[IF_PAR_LO+:2] != PAR_OFF));
    check(32'(data_clock_output), 32'(link_clk ^ ifb[IF_DCO_INV_BIT]));
    @(posedge clk);
    error_clear <= 1'b1;
    @(posedge clk);
    error_clear <= 1'b0;
    repeat (3) @(posedge clk);
    check(32'(parity_error | overrun_error), 32'h0);
  endtask : frame
  // Register clock, 50 ns.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Link clock, 48 ns, started 7 ns after the register clock; its edges still meet clk edges now and then.
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // Sample sink: random stalls driven on the rising edge.
  always @(posedge clk) begin
    rnd <= lfsr(rnd);
    sample_ready <= !stall && (rnd[1:0] != 2'h0);
  end
  // Handshake seen at the falling edge is the one the next rising edge takes; values are settled here.
  always @(negedge clk) begin
    if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
      if (expq.size() == 0) check(32'(sample), 32'hffffffff);
      else check(32'(sample), 32'(expq.pop_front()));
    end
  end
  // Main sequence: reset, register map, then the frame table.
  initial begin
    resetn = 1'b0;
    reg_wr_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    bus_mode_pin = 1'b1;
    ctrl_mode_pin = 1'b1;
    channel_enable = 4'h0;
    sample_ready = 1'b0;
    error_clear = 1'b0;
    stall = 1'b0;
    rnd = 32'he39deb52;
    n_errors = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (10) @(posedge clk);
    rd(IODP_ADDR_IF_CFG, 8'hc0 | IODP_IF_CFG_RST);
    rd(IODP_ADDR_FMT_CFG, IODP_FMT_CFG_RST);
    wr(IODP_ADDR_IF_CFG, 8'hff);
    wr(8'h33, 8'hff);
    rd(IODP_ADDR_IF_CFG, 8'hdf);
    rd(8'h33, 8'h00);
    rd(IODP_ADDR_FMT_CFG, 8'h00);
    foreach (tbl[i]) if (!timed_out) frame(tbl[i]);
    wrap_up();
  end
endmodule : tb_input_data_port_format_config
